/* File: hw/nvsc_pkg.sv */
// nvsc_pkg: constants, types and pin bundle of the store/recall host controller
// assumes one 10 MHz system clock; all times are turned into cycles here
package nvsc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // store cycle time, 10 ms, written in microseconds
  localparam int STORE_CYCLE_TIME_US = 10000;
  localparam int STORE_CYCLES = (STORE_CYCLE_TIME_US * 1000) / CLK_PERIOD_NS;
  // recall cycle time is not given; plain default, in microseconds
  localparam int RECALL_CYCLE_TIME_US = 100;
  localparam int RECALL_CYCLES = (RECALL_CYCLE_TIME_US * 1000) / CLK_PERIOD_NS;
  // host-held store request pulse, ns; rounded up to cycles
  localparam int HW_REQ_TIME_NS = 1000;
  localparam int HW_REQ_CYCLES = (HW_REQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strobe low time of one access, ns; rounded up
  localparam int STROBE_TIME_NS = 200;
  localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // cycles after releasing the request pin before it is trusted again
  localparam int SETTLE_CYCLES = 4;
  localparam int CNT_W = 20;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int SEQ_LEN = 6;
  // first five addresses of a software sequence, then the two triggers
  localparam logic [12:0] SEQ_ADDR_0 = 13'h0000;
  localparam logic [12:0] SEQ_ADDR_1 = 13'h1555;
  localparam logic [12:0] SEQ_ADDR_2 = 13'h0aaa;
  localparam logic [12:0] SEQ_ADDR_3 = 13'h1fff;
  localparam logic [12:0] SEQ_ADDR_4 = 13'h10f0;
  localparam logic [12:0] SEQ_STORE_ADDR = 13'h0f0f;
  localparam logic [12:0] SEQ_RECALL_ADDR = 13'h0f0e;

  typedef enum logic [2:0] {
    NVSC_OP_READ = 3'h0,
    NVSC_OP_WRITE = 3'h1,
    NVSC_OP_SW_STORE = 3'h2,
    NVSC_OP_SW_RECALL = 3'h3,
    NVSC_OP_HW_STORE = 3'h4
  } nvsc_op_t;

  // gray along idle-strobe-gap-wait; hardware store branch on the upper half
  typedef enum logic [2:0] {
    NVSC_ST_IDLE = 3'h0,
    NVSC_ST_STROBE = 3'h1,
    NVSC_ST_GAP = 3'h3,
    NVSC_ST_WAIT = 3'h2,
    NVSC_ST_HW_PULL = 3'h6,
    NVSC_ST_HW_WAIT = 3'h7
  } nvsc_state_t;

  typedef struct packed {
    nvsc_op_t op;
    logic [12:0] addr;
    logic [7:0] wdata;
  } nvsc_cmd_t;

  // memory-side bus driven by the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [12:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } nvsc_pins_t;
endpackage

/* File: hw/nvsc_host.sv */
// nvsc_host: host controller driving a shadow-nonvolatile byte SRAM through its pins
// assumes one clock sys_clk at 10 MHz and a synchronous active-high reset; the board
// resolves dq and the open-drain store/busy wire from the enables given here
`timescale 1ns/1ps
`default_nettype none
module nvsc_host #(
  parameter int STORE_CYCLES = nvsc_pkg::STORE_CYCLES,
  parameter int RECALL_CYCLES = nvsc_pkg::RECALL_CYCLES
) (
  input wire logic sys_clk, // system clock, 10 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic cmd_valid, // command offered
  input wire nvsc_pkg::nvsc_cmd_t cmd, // operation, address, write data
  output logic cmd_ready, // command taken when high with cmd_valid
  output logic rsp_valid, // one-cycle pulse, command finished
  output logic [7:0] rsp_rdata, // dq sampled at the end of the last access strobe, read or write
  output logic rsp_err, // hardware store wait timed out
  output nvsc_pkg::nvsc_pins_t pins, // memory bus outputs
  input wire logic [7:0] dq_in, // data pins as seen by the host
  input wire logic busy_n_in, // level of store_req_busy_n
  output logic busy_n_out, // drive value of store_req_busy_n, always low
  output logic busy_n_oe // high while the host pulls store_req_busy_n low
);
  nvsc_pkg::nvsc_state_t state_reg, state_next;
  nvsc_pkg::nvsc_op_t op_reg;
  nvsc_pkg::nvsc_pins_t pins_reg, pins_next;
  logic [7:0] wdata_reg, rdata_reg, rdata_next;
  logic [12:0] addr_reg;
  logic [2:0] step_reg, step_next;
  logic [19:0] cnt_reg, cnt_next, tmo_reg, tmo_next;
  logic [2:0] sync_reg;
  logic busy_level_reg, ready_reg, rsp_reg, rsp_next, err_reg, err_next, oe_reg, oe_next;

  // store_req_busy_n through three flops; level moves when the last two agree
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_reg <= 3'h7;
      busy_level_reg <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], busy_n_in};
      if (sync_reg[1] == sync_reg[2]) begin
        busy_level_reg <= sync_reg[2];
      end
    end
  end

  // decoding of the command and of the sequence address
  wire take = cmd_valid && ready_reg;
  wire is_sw = (op_reg == nvsc_pkg::NVSC_OP_SW_STORE) || (op_reg == nvsc_pkg::NVSC_OP_SW_RECALL);
  wire cmd_sw = (cmd.op == nvsc_pkg::NVSC_OP_SW_STORE) || (cmd.op == nvsc_pkg::NVSC_OP_SW_RECALL);
  wire cmd_wr = cmd.op == nvsc_pkg::NVSC_OP_WRITE;
  wire last_step = step_reg == 3'(nvsc_pkg::SEQ_LEN - 1);
  wire [2:0] nstep = step_reg + 3'h1;
  wire [12:0] trig_addr = (op_reg == nvsc_pkg::NVSC_OP_SW_STORE) ? nvsc_pkg::SEQ_STORE_ADDR
                                                               : nvsc_pkg::SEQ_RECALL_ADDR;
  wire [12:0] seq_addr = (nstep == 3'h1) ? nvsc_pkg::SEQ_ADDR_1 :
                         (nstep == 3'h2) ? nvsc_pkg::SEQ_ADDR_2 :
                         (nstep == 3'h3) ? nvsc_pkg::SEQ_ADDR_3 :
                         (nstep == 3'h4) ? nvsc_pkg::SEQ_ADDR_4 : trig_addr;
  wire [19:0] xfer_cycles = (op_reg == nvsc_pkg::NVSC_OP_SW_STORE) ? 20'(STORE_CYCLES) : 20'(RECALL_CYCLES);
  // a new command only while the device shows no store in progress
  wire ready_next = (state_next == nvsc_pkg::NVSC_ST_IDLE) && busy_level_reg;

  // sequencing of accesses, software sequences and hardware store requests
  always_comb begin
    state_next = state_reg;
    pins_next = pins_reg;
    step_next = step_reg;
    cnt_next = (cnt_reg != 20'h0) ? cnt_reg - 20'h1 : cnt_reg;
    tmo_next = tmo_reg;
    rdata_next = rdata_reg;
    rsp_next = 1'b0;
    err_next = err_reg;
    oe_next = oe_reg;
    case (state_reg)
      nvsc_pkg::NVSC_ST_IDLE: begin
        if (take && cmd.op == nvsc_pkg::NVSC_OP_HW_STORE) begin
          oe_next = 1'b1;
          cnt_next = 20'(nvsc_pkg::HW_REQ_CYCLES);
          state_next = nvsc_pkg::NVSC_ST_HW_PULL;
        end else if (take) begin
          // sequences are plain reads with output enable left high
          pins_next.addr = cmd_sw ? nvsc_pkg::SEQ_ADDR_0 : cmd.addr;
          pins_next.ce_n = 1'b0;
          pins_next.we_n = !cmd_wr;
          pins_next.oe_n = cmd_wr || cmd_sw;
          pins_next.dq_out = cmd.wdata;
          pins_next.dq_oe = cmd_wr;
          step_next = 3'h0;
          cnt_next = 20'(nvsc_pkg::STROBE_CYCLES);
          state_next = nvsc_pkg::NVSC_ST_STROBE;
        end
      end
      nvsc_pkg::NVSC_ST_STROBE: begin
        if (cnt_reg <= 20'h1) begin
          rdata_next = dq_in;
          pins_next.ce_n = 1'b1;
          pins_next.we_n = 1'b1;
          pins_next.oe_n = 1'b1;
          state_next = nvsc_pkg::NVSC_ST_GAP;
        end
      end
      nvsc_pkg::NVSC_ST_GAP: begin
        pins_next.dq_oe = 1'b0;
        if (is_sw && !last_step) begin
          // back to back reads keep the sequence unbroken
          step_next = nstep;
          pins_next.addr = seq_addr;
          pins_next.ce_n = 1'b0;
          cnt_next = 20'(nvsc_pkg::STROBE_CYCLES);
          state_next = nvsc_pkg::NVSC_ST_STROBE;
        end else if (is_sw) begin
          cnt_next = xfer_cycles;
          state_next = nvsc_pkg::NVSC_ST_WAIT;
        end else begin
          rsp_next = 1'b1;
          err_next = 1'b0;
          state_next = nvsc_pkg::NVSC_ST_IDLE;
        end
      end
      nvsc_pkg::NVSC_ST_WAIT: begin
        // no access until the transfer time is over
        if (cnt_reg <= 20'h1) begin
          rsp_next = 1'b1;
          err_next = 1'b0;
          state_next = nvsc_pkg::NVSC_ST_IDLE;
        end
      end
      nvsc_pkg::NVSC_ST_HW_PULL: begin
        if (cnt_reg <= 20'h1) begin
          oe_next = 1'b0;
          cnt_next = 20'(nvsc_pkg::SETTLE_CYCLES);
          tmo_next = 20'(STORE_CYCLES) + 20'(STORE_CYCLES);
          state_next = nvsc_pkg::NVSC_ST_HW_WAIT;
        end
      end
      nvsc_pkg::NVSC_ST_HW_WAIT: begin
        tmo_next = (tmo_reg != 20'h0) ? tmo_reg - 20'h1 : tmo_reg;
        if (cnt_reg == 20'h0 && (busy_level_reg || tmo_reg == 20'h0)) begin
          rsp_next = 1'b1;
          err_next = !busy_level_reg;
          state_next = nvsc_pkg::NVSC_ST_IDLE;
        end
      end
      default: begin
        state_next = nvsc_pkg::NVSC_ST_IDLE;
      end
    endcase
  end

  // state and output flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= nvsc_pkg::NVSC_ST_IDLE;
      pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 13'h0000, dq_out: 8'h00, dq_oe: 1'b0};
      step_reg <= 3'h0;
      cnt_reg <= 20'h0;
      tmo_reg <= 20'h0;
      rdata_reg <= 8'h00;
      rsp_reg <= 1'b0;
      err_reg <= 1'b0;
      oe_reg <= 1'b0;
      ready_reg <= 1'b0;
      op_reg <= nvsc_pkg::NVSC_OP_READ;
      addr_reg <= 13'h0000;
      wdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      pins_reg <= pins_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      tmo_reg <= tmo_next;
      rdata_reg <= rdata_next;
      rsp_reg <= rsp_next;
      err_reg <= err_next;
      oe_reg <= oe_next;
      ready_reg <= ready_next;
      if (take) begin
        op_reg <= cmd.op;
        addr_reg <= cmd.addr;
        wdata_reg <= cmd.wdata;
      end
    end
  end

  // outputs straight from flops, busy_n_out tied low
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign rsp_err = err_reg;
  assign pins = pins_reg;
  assign busy_n_out = 1'b0;
  assign busy_n_oe = oe_reg;

  // checks on the driven pins
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_sw_taken;
    take && cmd_sw;
  endsequence
  sequence s_first_read;
    !pins.ce_n && pins.we_n && pins.addr == nvsc_pkg::SEQ_ADDR_0;
  endsequence
  property p_seq_start;
    s_sw_taken |=> s_first_read;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence did not open at address zero");

  property p_seq_reads_only;
    (state_reg != nvsc_pkg::NVSC_ST_IDLE) && is_sw |-> pins.we_n && !pins.dq_oe;
  endproperty
  a_seq_reads_only: assert property (p_seq_reads_only) else $error("write strobe inside a sequence");

  property p_store_trigger;
    $rose(state_reg == nvsc_pkg::NVSC_ST_WAIT) && op_reg == nvsc_pkg::NVSC_OP_SW_STORE
      |-> pins.addr == nvsc_pkg::SEQ_STORE_ADDR && step_reg == 3'h5;
  endproperty
  a_store_trigger: assert property (p_store_trigger) else $error("store sequence ended on wrong address");

  property p_recall_trigger;
    $rose(state_reg == nvsc_pkg::NVSC_ST_WAIT) && op_reg == nvsc_pkg::NVSC_OP_SW_RECALL
      |-> pins.addr == nvsc_pkg::SEQ_RECALL_ADDR && step_reg == 3'h5;
  endproperty
  a_recall_trigger: assert property (p_recall_trigger) else $error("recall sequence ended on wrong address");

  // run length of the host pull on store_req_busy_n, read only by the checks below
  logic [4:0] pull_run_reg, pull_run_next;
  assign pull_run_next = oe_reg ? pull_run_reg + 5'h1 : 5'h0;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pull_run_reg <= 5'h0;
    end else begin
      pull_run_reg <= pull_run_next;
    end
  end

  property p_pull_short;
    busy_n_oe |-> pull_run_reg < 5'(nvsc_pkg::HW_REQ_CYCLES);
  endproperty
  a_pull_short: assert property (p_pull_short) else $error("store request held too long");

  property p_pin_release;
    $fell(busy_n_oe) |-> pull_run_reg == 5'(nvsc_pkg::HW_REQ_CYCLES);
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("store request not released on time");

  property p_no_access_in_wait;
    state_reg == nvsc_pkg::NVSC_ST_WAIT |-> pins.ce_n && pins.we_n;
  endproperty
  a_no_access_in_wait: assert property (p_no_access_in_wait) else $error("access during transfer wait");

  property p_write_only_when_free;
    $fell(pins.we_n) |-> $past(busy_level_reg, 2);
  endproperty
  a_write_only_when_free: assert property (p_write_only_when_free) else $error("write issued while busy low");

  property p_write_drives_data;
    !pins.we_n |-> !pins.ce_n && pins.dq_oe && pins.oe_n;
  endproperty
  a_write_drives_data: assert property (p_write_drives_data) else $error("write strobe without data drive");
endmodule // nvsc_host
`default_nettype wire

/* File: sim/nvsc_dev_model.sv */
// nvsc_dev_model: behavioural shadow-nonvolatile byte SRAM seen from its pins
// assumes the bench resolves dq and the pulled-up store/busy wire; times in sys_clk cycles
`timescale 1ns/1ps
`default_nettype none
module nvsc_dev_model #(
  parameter int STORE_T = 180,
  parameter int RECALL_T = 18,
  parameter int PWRUP_T = 8,
  parameter int ENTRY_T = 4,
  parameter bit AUTO_SAVE = 1'b1
) (
  input wire logic sys_clk, // bench clock used as time base
  input wire logic supply_ok, // high while supply is above power_fail_threshold
  input wire nvsc_pkg::nvsc_pins_t pins, // host bus pins
  input wire logic busy_n, // store/busy wire level
  output logic [7:0] dq, // data the device puts on dq
  output logic busy_pull // high while the device pulls the busy wire low
);
  logic [7:0] mem [0:8191];
  logic [7:0] nv [0:8191];
  nvsc_pkg::nvsc_pins_t pins_q;
  logic [7:0] last;
  logic pend;
  logic storing;
  logic wr_inh;
  logic rcl_req;
  int low_t;
  int idx;
  int cnt;
  wire logic drive = !pins.ce_n && !pins.oe_n && pins.we_n && cnt == 0;
  wire logic acc_end = pins.ce_n && !pins_q.ce_n;
  wire logic wr_start = !pins.ce_n && !pins.we_n && (pins_q.ce_n || pins_q.we_n);
  wire logic [12:0] a = pins_q.addr;
  // a released bus shows the inverse of its last value
  assign dq = drive ? mem[pins.addr] : ~last;
  assign busy_pull = storing;
  function automatic logic [12:0] seq_addr(input int i);
    case (i)
      0: return nvsc_pkg::SEQ_ADDR_0;
      1: return nvsc_pkg::SEQ_ADDR_1;
      2: return nvsc_pkg::SEQ_ADDR_2;
      3: return nvsc_pkg::SEQ_ADDR_3;
      default: return nvsc_pkg::SEQ_ADDR_4;
    endcase
  endfunction
  // power-up recall: arbitrary preset pattern copied into the SRAM
  initial begin
    for (int i = 0; i < 8192; i++) begin
      nv[i] = i[7:0] ^ 8'h5a;
      mem[i] = nv[i];
    end
    pins_q = '1;
    last = 8'h00;
    pend = 1'b0;
    storing = 1'b0;
    wr_inh = 1'b0;
    rcl_req = 1'b0;
    low_t = 0;
    idx = 0;
    cnt = PWRUP_T;
  end
  // access decode, sequence tracking and transfer timing
  always @(posedge sys_clk) begin
    pins_q <= pins;
    if (drive) last <= mem[pins.addr];
    low_t <= busy_n ? 0 : low_t + 1;
    // a write that starts while the wire or the supply is low is refused
    if (wr_start) wr_inh <= !busy_n || !supply_ok;
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) storing <= 1'b0;
      if (cnt == 1 && !pins.ce_n && !pins.we_n) wr_inh <= 1'b1;
    end else if (!supply_ok) begin
      // below the threshold: latch a recall and save once if a write is pending
      rcl_req <= 1'b1;
      if (AUTO_SAVE && pend) begin
        nv <= mem;
        pend <= 1'b0;
        storing <= 1'b1;
        cnt <= STORE_T;
      end
    end else if (rcl_req) begin
      mem <= nv;
      pend <= 1'b0;
      rcl_req <= 1'b0;
      cnt <= PWRUP_T;
    end else if (!busy_n && !storing && pend && low_t == ENTRY_T) begin
      nv <= mem;
      pend <= 1'b0;
      storing <= 1'b1;
      cnt <= STORE_T;
    end else if (acc_end && !pins_q.we_n) begin
      if (!wr_inh) begin
        mem[a] <= pins_q.dq_out;
        pend <= 1'b1;
      end
      idx <= 0;
    end else if (acc_end) begin
      if (idx == 5 && a == nvsc_pkg::SEQ_STORE_ADDR) begin
        nv <= mem;
        pend <= 1'b0;
        storing <= 1'b1;
        cnt <= STORE_T;
        idx <= 0;
      end else if (idx == 5 && a == nvsc_pkg::SEQ_RECALL_ADDR) begin
        mem <= nv;
        pend <= 1'b0;
        cnt <= RECALL_T;
        idx <= 0;
      end else if (idx < 5 && a == seq_addr(idx)) begin
        idx <= idx + 1;
      end else begin
        idx <= (a == nvsc_pkg::SEQ_ADDR_0) ? 1 : 0;
      end
    end
  end
endmodule // nvsc_dev_model
`default_nettype wire

/* File: sim/nvsc_host_tb_top.sv */
// nvsc_host_tb_top: self-checking bench of the host controller against the device model
// assumes the design package and nvsc_host; dq and the busy wire are resolved here
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_tb_top;
  localparam int LIM = 1000;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  nvsc_pkg::nvsc_cmd_t cmd = '0;
  logic supply_ok = 1'b1;
  logic cmd_ready, rsp_valid, rsp_err, busy_n_out, busy_n_oe, dev_pull;
  logic [7:0] rsp_rdata, dev_dq;
  nvsc_pkg::nvsc_pins_t pins;
  wire logic [7:0] dq_w = pins.dq_oe ? pins.dq_out : dev_dq;
  wire logic busy_w = !((busy_n_oe && !busy_n_out) || dev_pull);
  int num_errors = 0;
  int samples_checked = 0;
  int low_cnt = 0;
  int lat, l0;
  logic [7:0] mem_exp [0:8191];
  logic [7:0] nv_exp [0:8191];
  logic [12:0] wa [0:15];

  always #50 sys_clk = ~sys_clk;
  // cycles with the busy wire low
  always @(posedge sys_clk) if (busy_w === 1'b0) low_cnt <= low_cnt + 1;

  nvsc_host #(.STORE_CYCLES(200), .RECALL_CYCLES(20)) u_nvsc_host (
    .sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .pins(pins), .dq_in(dq_w),
    .busy_n_in(busy_w), .busy_n_out(busy_n_out), .busy_n_oe(busy_n_oe));
  nvsc_dev_model #(.STORE_T(180), .RECALL_T(18), .PWRUP_T(8)) u_nvsc_dev_model (
    .sys_clk(sys_clk), .supply_ok(supply_ok), .pins(pins), .busy_n(busy_w), .dq(dev_dq), .busy_pull(dev_pull));

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // offer one command, wait for take and response; entered just after a rising edge
  task automatic op(input nvsc_pkg::nvsc_op_t o, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= '{op: o, addr: a, wdata: d};
    do begin @(posedge sys_clk); n++; end while (cmd_ready !== 1'b1 && n < LIM);
    cmd_valid <= 1'b0;
    lat = 0;
    do begin @(posedge sys_clk); lat++; end while (rsp_valid !== 1'b1 && lat < LIM);
    if (n >= LIM || lat >= LIM) chk(8'hee, 8'h00);
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    op(nvsc_pkg::NVSC_OP_WRITE, a, d);
    mem_exp[a] = d;
  endtask
  task automatic rd_chk(input logic [12:0] a);
    op(nvsc_pkg::NVSC_OP_READ, a, 8'h00);
    chk(rsp_rdata, mem_exp[a]);
  endtask
  // a pin-requested store runs long only when a write is pending
  function automatic logic [7:0] exp_long(input logic pending);
    return {7'h0, pending};
  endfunction
  // first five addresses of a software sequence
  function automatic logic [12:0] seq_at(input int i);
    case (i)
      0: return nvsc_pkg::SEQ_ADDR_0;
      1: return nvsc_pkg::SEQ_ADDR_1;
      2: return nvsc_pkg::SEQ_ADDR_2;
      3: return nvsc_pkg::SEQ_ADDR_3;
      default: return nvsc_pkg::SEQ_ADDR_4;
    endcase
  endfunction

  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end

  initial begin
    for (int i = 0; i < 8192; i++) begin
      nv_exp[i] = i[7:0] ^ 8'h5a;
      mem_exp[i] = nv_exp[i];
    end
    void'($urandom(32'heb11));
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_chk(13'h0123);
    // random writes with both address ends, then read back
    for (int i = 0; i < 16; i++) begin
      wa[i] = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($urandom_range(8191, 0));
      wr(wa[i], 8'($urandom));
    end
    for (int i = 0; i < 16; i++) rd_chk(wa[i]);
    // software store holds the busy wire low for its run
    l0 = low_cnt;
    op(nvsc_pkg::NVSC_OP_SW_STORE, 13'h0000, 8'h00);
    nv_exp = mem_exp;
    chk(8'(low_cnt - l0 >= 100), 8'h01);
    for (int i = 2; i < 6; i++) wr(wa[i], 8'($urandom));
    op(nvsc_pkg::NVSC_OP_SW_RECALL, 13'h0000, 8'h00);
    mem_exp = nv_exp;
    for (int i = 0; i < 6; i++) rd_chk(wa[i]);
    // host-built read sequence, whole and broken by a write
    for (int k = 0; k < 2; k++) begin
      wr(13'h0100, 8'($urandom));
      for (int j = 0; j < 5; j++) op(nvsc_pkg::NVSC_OP_READ, seq_at(j), 8'h00);
      if (k == 1) wr(13'h0100, 8'($urandom));
      op(nvsc_pkg::NVSC_OP_READ, nvsc_pkg::SEQ_STORE_ADDR, 8'h00);
      if (k == 0) nv_exp = mem_exp;
      wr(13'h0100, 8'($urandom));
      op(nvsc_pkg::NVSC_OP_SW_RECALL, 13'h0000, 8'h00);
      mem_exp = nv_exp;
      rd_chk(13'h0100);
    end
    // pin-requested store without and with a pending write
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(13'h0200, 8'($urandom));
      op(nvsc_pkg::NVSC_OP_HW_STORE, 13'h0000, 8'h00);
      chk(8'(lat > 100), exp_long(k == 1));
      chk({7'h0, rsp_err}, 8'h00);
    end
    nv_exp = mem_exp;
    wr(13'h0200, 8'($urandom));
    op(nvsc_pkg::NVSC_OP_SW_RECALL, 13'h0000, 8'h00);
    mem_exp = nv_exp;
    rd_chk(13'h0200);
    // supply loss saves a pending write; the recall after power returns brings it back
    wr(13'h0300, ~mem_exp[13'h0300]);
    nv_exp = mem_exp;
    l0 = low_cnt;
    supply_ok <= 1'b0;
    repeat (300) @(posedge sys_clk);
    supply_ok <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(8'(low_cnt - l0 >= 100), 8'h01);
    rd_chk(13'h0300);
    test_done();
  end
endmodule // nvsc_host_tb_top
`default_nettype wire
